// *** pkg/frdp_consts.vh ***
`ifndef FRDP_CONSTS_VH
`define FRDP_CONSTS_VH

// Register byte offsets
`define FRDP_OFF_CTRL 8'h00
`define FRDP_OFF_RDIV 8'h04
`define FRDP_OFF_NINT 8'h08
`define FRDP_OFF_NUM 8'h0c
`define FRDP_OFF_DEN 8'h10
`define FRDP_OFF_CHAN 8'h14
`define FRDP_OFF_STAT 8'h18

// Control register field positions
`define FRDP_CTRL_CAL 0
`define FRDP_CTRL_SYNC 1
`define FRDP_CTRL_DBL 2
`define FRDP_CTRL_SMDIV_LO 3
`define FRDP_CTRL_SMDIV_HI 5
`define FRDP_CTRL_ORD_LO 6
`define FRDP_CTRL_ORD_HI 8
`define FRDP_CTRL_DLY_LO 9
`define FRDP_CTRL_DLY_HI 11

// Channel register field positions
`define FRDP_CHAN_HIGH_BIT 16

// Divider limits
`define FRDP_PRE_MAX 8'h80
`define FRDP_POST_MAX 8'hff
`define FRDP_N_MIN 19'h0001c
`define FRDP_N_MAX 19'h7ffff
`define FRDP_CHAN_MAX 8'hc0
`define FRDP_CHAN_HIGH_MAX 8'h06
`define FRDP_ORD_MAX 3'h4
`define FRDP_SMDIV_MAX 3'h4

// Reset values
`define FRDP_RST_PRE 8'h01
`define FRDP_RST_POST 8'h01
`define FRDP_RST_N 19'h00064
`define FRDP_RST_NUM 32'h00000000
`define FRDP_RST_DEN 32'h00000001
`define FRDP_RST_CHAN 8'h01
`define FRDP_RST_XDIV 8'h01

// Calibration length in state machine clock ticks
`define FRDP_CAL_TICKS 16'h0040

`endif

// *** rtl/frdp_div.v ***
`timescale 1ns/1ps
// Programmable tick divider: one output pulse every divisor input ticks
module frdp_div #(
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire restart,
  input wire tick,
  input wire [W-1:0] divisor,
  output reg pulse
);
  reg [W-1:0] count;

  // Divisor of one or zero passes every tick
  always @(posedge clk) begin
    if (rst || restart) begin
      count <= {W{1'b0}};
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (count + {{(W-1){1'b0}}, 1'b1} >= divisor) begin
          count <= {W{1'b0}};
          pulse <= 1'b1;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// *** rtl/frdp_top.v ***
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "frdp_consts.vh"
module frdp_top #(
  parameter [15:0] CAL_TICKS = `FRDP_CAL_TICKS
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire referenceInput,
  input wire vcoInput,
  output wire pfdRefPulse,
  output wire pfdFbPulse,
  output wire smClkTick,
  output reg rfOutput,
  output reg calBusy,
  output reg [2:0] pfdDelaySelect
);
  // Staged settings written by software
  reg [7:0] stPre;
  reg [7:0] stPost;
  reg [18:0] stN;
  reg [31:0] stNum;
  reg [31:0] stDen;
  reg [7:0] stChan;
  reg [7:0] stXdiv;
  reg stHigh;
  // Active settings
  reg [7:0] actPre;
  reg [7:0] actPost;
  reg [18:0] actN;
  reg [31:0] actNum;
  reg [31:0] actDen;
  reg [7:0] actChan;
  reg [7:0] actXdiv;
  reg referenceDoublerSel;
  reg syncMode;
  reg [2:0] calClkDiv;
  reg [2:0] mashOrder;
  reg chanLimited;
  // Pin synchronisers and edge history
  reg refMeta;
  reg refSync;
  reg refLast;
  reg vcoMeta;
  reg vcoSync;
  reg vcoLast;
  // Modulator state
  reg [31:0] acc1;
  reg [31:0] acc2;
  reg [31:0] acc3;
  reg [31:0] acc4;
  reg [2:0] c2d;
  reg [2:0] c3d;
  reg [2:0] c4d;
  reg [20:0] fbModulus;
  reg [15:0] calCount;
  reg [7:0] calRuns;

  wire setupPhase = psel & ~penable;
  wire wrAccess = psel & penable & pwrite;
  wire ctrlWrite = wrAccess & (paddr == `FRDP_OFF_CTRL);
  wire refRise = refSync & ~refLast;
  wire refFall = ~refSync & refLast;
  wire vcoRise = vcoSync & ~vcoLast;
  wire vcoFall = ~vcoSync & vcoLast;
  wire [18:0] preClamp;
  wire [18:0] postClamp;
  wire [18:0] chanClamp;
  wire preTick;
  wire fbMainPulse;
  wire chanPulse;
  wire [32:0] s1;
  wire [32:0] s2;
  wire [32:0] s3;
  wire [32:0] s4;
  reg signed [5:0] corr;
  reg signed [21:0] nextModulus;

  // Keep a divide value inside lo..hi
  function [18:0] clampVal;
    input [31:0] v;
    input [18:0] lo;
    input [18:0] hi;
    begin
      if (v < {13'h0000, lo})
        clampVal = lo;
      else if (v > {13'h0000, hi})
        clampVal = hi;
      else
        clampVal = v[18:0];
    end
  endfunction

  // Modulo-denominator accumulate: carry and new sum
  function [32:0] accStep;
    input [31:0] acc;
    input [31:0] inc;
    input [31:0] frac_denominator;
    reg [32:0] sum;
    begin
      sum = {1'b0, acc} + {1'b0, inc};
      if (sum >= {1'b0, frac_denominator})
        accStep = {1'b1, sum[31:0] - frac_denominator};
      else
        accStep = {1'b0, sum[31:0]};
    end
  endfunction

  // Two-flop synchronisers on the pins
  always @(posedge clk) begin
    if (rst) begin
      refMeta <= 1'b0;
      refSync <= 1'b0;
      refLast <= 1'b0;
      vcoMeta <= 1'b0;
      vcoSync <= 1'b0;
      vcoLast <= 1'b0;
    end else begin
      refMeta <= referenceInput;
      refSync <= refMeta;
      refLast <= refSync;
      vcoMeta <= vcoInput;
      vcoSync <= vcoMeta;
      vcoLast <= vcoSync;
    end
  end

  // Doubler: both edges when selected, rising only otherwise
  wire refTick = refRise | (referenceDoublerSel & refFall);

  // Divider fields held inside their legal ranges
  assign preClamp = clampVal({24'h000000, pwdata[7:0]}, 19'h00001,
    {11'h000, `FRDP_PRE_MAX});
  assign postClamp = clampVal({24'h000000, pwdata[15:8]}, 19'h00001,
    {11'h000, `FRDP_POST_MAX});
  assign chanClamp = clampVal({24'h000000, pwdata[7:0]}, 19'h00001,
    {11'h000, `FRDP_CHAN_MAX});

  // APB register writes; staged values wait for a control write
  always @(posedge clk) begin
    if (rst) begin
      stPre <= `FRDP_RST_PRE;
      stPost <= `FRDP_RST_POST;
      stN <= `FRDP_RST_N;
      stNum <= `FRDP_RST_NUM;
      stDen <= `FRDP_RST_DEN;
      stChan <= `FRDP_RST_CHAN;
      stXdiv <= `FRDP_RST_XDIV;
      stHigh <= 1'b0;
    end else if (wrAccess) begin
      case (paddr)
        `FRDP_OFF_RDIV: begin
          stPre <= preClamp[7:0];
          stPost <= postClamp[7:0];
        end
        `FRDP_OFF_NINT: begin
          stN <= clampVal(pwdata, `FRDP_N_MIN, `FRDP_N_MAX);
        end
        `FRDP_OFF_NUM: begin
          stNum <= pwdata;
        end
        `FRDP_OFF_DEN: begin
          stDen <= (pwdata == 32'h00000000) ? 32'h00000001 : pwdata;
        end
        `FRDP_OFF_CHAN: begin
          stChan <= chanClamp[7:0];
          stXdiv <= (pwdata[15:8] == 8'h00) ? 8'h01 : pwdata[15:8];
          stHigh <= pwdata[`FRDP_CHAN_HIGH_BIT];
        end
        default: begin
          stPre <= stPre;
        end
      endcase
    end
  end

  // Control write applies every staged setting in one edge
  always @(posedge clk) begin
    if (rst) begin
      actPre <= `FRDP_RST_PRE;
      actPost <= `FRDP_RST_POST;
      actN <= `FRDP_RST_N;
      actNum <= `FRDP_RST_NUM;
      actDen <= `FRDP_RST_DEN;
      actChan <= `FRDP_RST_CHAN;
      actXdiv <= `FRDP_RST_XDIV;
      chanLimited <= 1'b0;
      referenceDoublerSel <= 1'b0;
      syncMode <= 1'b0;
      calClkDiv <= 3'h0;
      mashOrder <= 3'h0;
      pfdDelaySelect <= 3'h0;
    end else if (ctrlWrite) begin
      actPre <= stPre;
      actPost <= stPost;
      actN <= stN;
      actNum <= (stNum >= stDen) ? stDen - 32'h00000001 : stNum;
      actDen <= stDen;
      // High band caps the channel divide
      if (stHigh && stChan > `FRDP_CHAN_HIGH_MAX) begin
        actChan <= `FRDP_CHAN_HIGH_MAX;
        chanLimited <= 1'b1;
      end else begin
        actChan <= stChan;
        chanLimited <= 1'b0;
      end
      actXdiv <= stXdiv;
      referenceDoublerSel <= pwdata[`FRDP_CTRL_DBL];
      syncMode <= pwdata[`FRDP_CTRL_SYNC];
      calClkDiv <= (pwdata[`FRDP_CTRL_SMDIV_HI:`FRDP_CTRL_SMDIV_LO] >
        `FRDP_SMDIV_MAX) ? `FRDP_SMDIV_MAX :
        pwdata[`FRDP_CTRL_SMDIV_HI:`FRDP_CTRL_SMDIV_LO];
      mashOrder <= (pwdata[`FRDP_CTRL_ORD_HI:`FRDP_CTRL_ORD_LO] >
        `FRDP_ORD_MAX) ? `FRDP_ORD_MAX :
        pwdata[`FRDP_CTRL_ORD_HI:`FRDP_CTRL_ORD_LO];
      pfdDelaySelect <= pwdata[`FRDP_CTRL_DLY_HI:`FRDP_CTRL_DLY_LO];
    end
  end

  // Reference path: pre then post divider gives the phase detector pulse
  frdp_div #(.W(8)) preDiv (
    .clk(clk),
    .rst(rst),
    .restart(ctrlWrite),
    .tick(refTick),
    .divisor(actPre),
    .pulse(preTick)
  );

  frdp_div #(.W(8)) postDiv (
    .clk(clk),
    .rst(rst),
    .restart(ctrlWrite),
    .tick(preTick),
    .divisor(actPost),
    .pulse(pfdRefPulse)
  );

  // State machine clock from undoubled rising reference edges
  frdp_div #(.W(5)) smDiv (
    .clk(clk),
    .rst(rst),
    .restart(ctrlWrite),
    .tick(refRise),
    .divisor(5'h01 << calClkDiv),
    .pulse(smClkTick)
  );

  // MASH accumulator chain
  assign s1 = accStep(acc1, actNum, actDen);
  assign s2 = accStep(acc2, s1[31:0], actDen);
  assign s3 = accStep(acc3, s2[31:0], actDen);
  assign s4 = accStep(acc4, s3[31:0], actDen);

  // Combine stage carries by the selected order
  always @* begin
    corr = 6'sd0;
    nextModulus = 22'sd0;
    case (mashOrder)
      3'h1: begin
        corr = {5'h00, s1[32]};
      end
      3'h2: begin
        corr = {5'h00, s1[32]} + {5'h00, s2[32]} - {5'h00, c2d[0]};
      end
      3'h3: begin
        corr = {5'h00, s1[32]} + {5'h00, s2[32]} - {5'h00, c2d[0]}
          + {5'h00, s3[32]} - {4'h0, c3d[0], 1'b0} + {5'h00, c3d[1]};
      end
      3'h4: begin
        corr = {5'h00, s1[32]} + {5'h00, s2[32]} - {5'h00, c2d[0]}
          + {5'h00, s3[32]} - {4'h0, c3d[0], 1'b0} + {5'h00, c3d[1]}
          + {5'h00, s4[32]} - {5'h00, c4d[0]} - {4'h0, c4d[0], 1'b0}
          + {5'h00, c4d[1]} + {4'h0, c4d[1], 1'b0} - {5'h00, c4d[2]};
      end
      default: begin
        corr = 6'sd0;
      end
    endcase
    nextModulus = $signed({3'h0, actN}) + corr;
  end

  // Modulator steps once per feedback cycle; control write clears it
  always @(posedge clk) begin
    if (rst || ctrlWrite) begin
      acc1 <= 32'h00000000;
      acc2 <= 32'h00000000;
      acc3 <= 32'h00000000;
      acc4 <= 32'h00000000;
      c2d <= 3'h0;
      c3d <= 3'h0;
      c4d <= 3'h0;
      fbModulus <= {2'h0, stN};
    end else if (fbMainPulse) begin
      acc1 <= s1[31:0];
      acc2 <= s2[31:0];
      acc3 <= s3[31:0];
      acc4 <= s4[31:0];
      c2d <= {c2d[1:0], s2[32]};
      c3d <= {c3d[1:0], s3[32]};
      c4d <= {c4d[1:0], s4[32]};
      fbModulus <= nextModulus[20:0];
    end
  end

  // Feedback divider counts VCO edges by the modulated modulus
  frdp_div #(.W(21)) fbDiv (
    .clk(clk),
    .rst(rst),
    .restart(ctrlWrite),
    .tick(vcoRise),
    .divisor(fbModulus),
    .pulse(fbMainPulse)
  );

  // Extra divide only in sync mode
  frdp_div #(.W(8)) xDiv (
    .clk(clk),
    .rst(rst),
    .restart(ctrlWrite),
    .tick(fbMainPulse),
    .divisor(syncMode ? actXdiv : 8'h01),
    .pulse(pfdFbPulse)
  );

  // Output channel divider counts both VCO edges, so the output period
  // is the divide value in VCO periods, odd values included
  frdp_div #(.W(8)) chDiv (
    .clk(clk),
    .rst(rst),
    .restart(ctrlWrite),
    .tick(vcoRise | vcoFall),
    .divisor(actChan),
    .pulse(chanPulse)
  );

  // Bypass follows the VCO, otherwise toggle per channel count
  always @(posedge clk) begin
    if (rst) begin
      rfOutput <= 1'b0;
    end else if (actChan == 8'h01) begin
      rfOutput <= vcoSync;
    end else if (chanPulse) begin
      rfOutput <= ~rfOutput;
    end
  end

  // Calibration runs for a fixed number of state machine ticks
  always @(posedge clk) begin
    if (rst) begin
      calBusy <= 1'b0;
      calCount <= 16'h0000;
      calRuns <= 8'h00;
    end else if (ctrlWrite && pwdata[`FRDP_CTRL_CAL]) begin
      calBusy <= 1'b1;
      calCount <= 16'h0000;
      calRuns <= calRuns + 8'h01;
    end else if (calBusy && smClkTick) begin
      if (calCount + 16'h0001 >= CAL_TICKS) begin
        calBusy <= 1'b0;
      end
      calCount <= calCount + 16'h0001;
    end
  end

  // Read data and error captured in the setup phase
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= 1'b0;
      case (paddr)
        `FRDP_OFF_CTRL: prdata <= {20'h00000, pfdDelaySelect, mashOrder,
          calClkDiv, referenceDoublerSel, syncMode, calBusy};
        `FRDP_OFF_RDIV: prdata <= {16'h0000, stPost, stPre};
        `FRDP_OFF_NINT: prdata <= {13'h0000, stN};
        `FRDP_OFF_NUM: prdata <= stNum;
        `FRDP_OFF_DEN: prdata <= stDen;
        `FRDP_OFF_CHAN: prdata <= {15'h0000, stHigh, stXdiv, stChan};
        `FRDP_OFF_STAT: prdata <= {14'h0000, chanLimited, calBusy, calRuns,
          actChan};
        default: begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Zero wait states: access phase completes at once
  assign pready = penable;
endmodule

// *** verif/frdp_ref_osc.sv ***
`timescale 1ns/1ps
// Free running square wave standing in for an external oscillator
module frdp_ref_osc #(
  parameter int HALF = 5
) (
  output logic clkOut
);
  // Even duty and always running, so calibration has a clock
  initial begin
    clkOut = 1'b0;
    #3;
    forever begin
      #(HALF * 10);
      clkOut = ~clkOut;
    end
  end
endmodule

// *** verif/frdp_top_monitor.sv ***
`timescale 1ns/1ps
// Watches the bus and divider outputs
module frdp_top_monitor #(
  parameter [15:0] CAL_TICKS = 16'h0040
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire referenceInput,
  input wire vcoInput,
  input wire pfdRefPulse,
  input wire pfdFbPulse,
  input wire smClkTick,
  input wire rfOutput,
  input wire calBusy,
  input wire [2:0] pfdDelaySelect
);
  logic [15:0] calLen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles spent calibrating
  always @(posedge clk)
    if (rst || !calBusy)
      calLen <= 16'h0000;
    else
      calLen <= calLen + 16'h0001;
  // Bus phases
  sequence setupRd;
    psel && !penable && !pwrite;
  endsequence
  sequence ctrlWr;
    psel && penable && pwrite && paddr == 8'h00;
  endsequence
  sequence calWr;
    ctrlWr ##0 pwdata[0];
  endsequence
  chk_bus_nowait: assert property (psel && penable |-> pready)
    else $error("no pready");
  chk_hole_err: assert property (setupRd ##0 paddr > 8'h18 |=>
    pslverr && prdata == 32'h0) else $error("hole not refused");
  chk_map_ok: assert property (setupRd ##0 paddr <= 8'h18 |=> !pslverr)
    else $error("mapped read refused");
  chk_dly_load: assert property (ctrlWr |=>
    pfdDelaySelect == $past(pwdata[11:9])) else $error("delay not loaded");
  chk_dly_hold: assert property (!(psel && penable && pwrite &&
    paddr == 8'h00) |=> $stable(pfdDelaySelect)) else $error("delay moved");
  chk_cal_start: assert property (calWr |-> ##[1:4] calBusy)
    else $error("calibration not started");
  chk_cal_length: assert property (!$past(rst) && $fell(calBusy) |->
    calLen >= CAL_TICKS) else $error("calibration too short");
  chk_ref_single: assert property (pfdRefPulse |=> !pfdRefPulse)
    else $error("long reference pulse");
  chk_fb_single: assert property (pfdFbPulse |=> !pfdFbPulse)
    else $error("long feedback pulse");
  chk_sm_single: assert property (smClkTick |=> !smClkTick)
    else $error("long state machine tick");
endmodule

bind frdp_top frdp_top_monitor #(.CAL_TICKS(CAL_TICKS))
  frdp_top_monitor_inst (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .referenceInput(referenceInput), .vcoInput(vcoInput),
  .pfdRefPulse(pfdRefPulse), .pfdFbPulse(pfdFbPulse),
  .smClkTick(smClkTick), .rfOutput(rfOutput), .calBusy(calBusy),
  .pfdDelaySelect(pfdDelaySelect));

// *** verif/frdp_top_tb.sv ***
`timescale 1ns/1ps
module frdp_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, refIn, vcoIn, refP, fbP, smTick, rf_output;
  logic busy, rfPrev;
  logic [2:0] dly;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n, s1, s2;
  logic [31:0] rv [7] = '{32'h0, 32'h101, 32'h64, 32'h0, 32'h1, 32'h101,
    32'h1};
  logic [7:0] ba [4] = '{8'h04, 8'h08, 8'h10, 8'h14};
  logic [31:0] bd [4] = '{32'hff80, 32'h7ffff, 32'hffffffff, 32'h101c0};

  // Reference and VCO sources, unrelated in phase to the bus clock
  frdp_ref_osc #(.HALF(5)) refOsc (.clkOut(refIn));
  frdp_ref_osc #(.HALF(2)) vcoOsc (.clkOut(vcoIn));
  frdp_top #(.CAL_TICKS(16'h0004)) frdp_top_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .referenceInput(refIn), .vcoInput(vcoIn), .pfdRefPulse(refP),
    .pfdFbPulse(fbP), .smClkTick(smTick), .rfOutput(rf_output),
    .calBusy(busy), .pfdDelaySelect(dly));

  // Clock, output history and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    rfPrev <= rf_output;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; data and error are taken at the pready edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  function automatic logic hit(int sel);
    case (sel)
      0: return refP;
      1: return fbP;
      2: return smTick;
      default: return rf_output & ~rfPrev;
    endcase
  endfunction

  // Cycles until k more pulses of the chosen output
  task automatic cnt(int sel, int k);
    n = 0;
    repeat (k)
      do begin
        @(posedge clk);
        n++;
      end while (hit(sel) !== 1'b1);
  endtask

  task automatic meas(int sel, int k);
    cnt(sel, 1);
    cnt(sel, k);
  endtask

  // Feedback periods after a fresh control write, folded together
  task automatic sig(output int s);
    wr(8'h00, 32'h80);
    cnt(1, 1);
    s = 0;
    repeat (6) begin
      cnt(1, 1);
      s = s * 7 + n;
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset contents, then a hole in the map
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check("reset", rd, rv[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    check("hole", {err, rd[30:0]}, 32'h80000000);
    // Widest legal settings are kept as written
    for (int i = 0; i < 4; i++) begin
      wr(ba[i], bd[i]);
      apb(1'b0, ba[i], 32'h0);
      check("limit", rd, bd[i]);
    end
    // Reference path rates
    wr(8'h04, 32'h302);
    wr(8'h08, 32'h1c);
    wr(8'h10, 32'h1);
    wr(8'h14, 32'h103);
    wr(8'h00, 32'he00);
    meas(0, 1);
    check("ref", n, 60);
    check("delay", dly, 7);
    wr(8'h00, 32'h4);
    meas(0, 1);
    check("doubled", n, 30);
    for (int k = 0; k < 6; k++) begin
      wr(8'h00, 32'(k << 3));
      meas(2, 1);
      check("smclk", n, 10 << (k > 4 ? 4 : k));
    end
    // Feedback and channel dividers, staged until control write
    meas(1, 1);
    check("integer", n, 112);
    meas(3, 1);
    check("channel", n, 12);
    wr(8'h14, 32'h206);
    meas(3, 1);
    check("staged", n, 12);
    wr(8'h00, 32'h2);
    meas(1, 1);
    check("sync", n, 224);
    wr(8'h14, 32'h1020a);
    wr(8'h00, 32'h0);
    meas(3, 1);
    check("capped", n, 24);
    meas(1, 1);
    check("no sync", n, 112);
    apb(1'b0, 8'h18, 32'h0);
    check("flag", {rd[17], rd[7:0]}, 32'h106);
    // Half-step fraction for every modulator order
    wr(8'h14, 32'h103);
    wr(8'h0c, 32'h1);
    wr(8'h10, 32'h2);
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, 32'(k << 6));
      meas(1, 16);
      check("frac", k ? n > 1760 && n < 1888 : n == 1792, 1);
    end
    // Denominator five so a missed modulator reset shifts the sequence
    wr(8'h10, 32'h5);
    sig(s1);
    sig(s2);
    check("repeat", s1, s2);
    // Calibration shows busy, then ends
    wr(8'h00, 32'h1);
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    check("busy", rd[0], 1);
    cnt(2, 12);
    check("done", busy, 0);
    stop_test();
  end
endmodule
